// >>> bench/chain_write_frame_decoder_test.sv
`timescale 1ns/1ps
`include "chain_frame_defines.svh"
module chain_write_frame_decoder_test;
  import chain_frame_pkg::*;
  logic mclk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic rx_valid_i, rx_sof_i, frame_end_i, crc_ok_i;
  logic [7:0] rx_byte_i;
  logic [4:0] dev_addr_i = 5'h00;
  logic [7:0] group_id_i = 8'h00;
  logic [31:0] chan_sel_i = 32'h0000_0000;
  logic reg_wr_o, trig_stb_o, resp_req_o, resp_first_o;
  logic [15:0] reg_addr_o;
  logic [7:0] reg_data_o, trig_val_o, scratch_byte_o;
  logic [6:0] resp_len_o;
  logic [4:0] resp_high_o;
  int miscompares = 0;
  int comparisons = 0;
  int nwr, nresp, ntrig;
  logic rf;
  logic [15:0] wa [8];
  logic [7:0] wd [8];
  logic [31:0] seed = 32'h0000_000D;
  logic [7:0] g, a, d, b;
  logic [4:0] h;
  logic [6:0] l;

  always #5 mclk_i = ~mclk_i;

  host_frame_model host (.mclk_i(mclk_i), .rx_valid_o(rx_valid_i), .rx_sof_o(rx_sof_i),
    .rx_byte_o(rx_byte_i), .frame_end_o(frame_end_i), .crc_ok_o(crc_ok_i));

  chain_write_frame_decoder uut (.mclk_i(mclk_i), .rstn_i(rstn_i), .rx_valid_i(rx_valid_i),
    .rx_sof_i(rx_sof_i), .rx_byte_i(rx_byte_i), .frame_end_i(frame_end_i), .crc_ok_i(crc_ok_i),
    .dev_addr_i(dev_addr_i), .group_id_i(group_id_i), .chan_sel_i(chan_sel_i),
    .reg_wr_o(reg_wr_o), .reg_addr_o(reg_addr_o), .reg_data_o(reg_data_o),
    .trig_stb_o(trig_stb_o), .trig_val_o(trig_val_o), .scratch_byte_o(scratch_byte_o),
    .resp_req_o(resp_req_o), .resp_len_o(resp_len_o), .resp_high_o(resp_high_o),
    .resp_first_o(resp_first_o));

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  // Length minus one for a command-triggered reply: one byte per selected channel
  function automatic logic [6:0] trig_len(input logic [31:0] sel);
    int n;
    n = $countones(sel);
    return (n == 0) ? 7'h00 : 7'(n - 1);
  endfunction

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // Sends one frame and gathers everything the decoder does in the following cycles
  task automatic tx(input logic [63:0] fb, input int n, input logic good);
    host.send(fb, n, good);
    nwr = 0;
    nresp = 0;
    ntrig = 0;
    rf = 1'b0;
    // Pulses launched by the frame-end edge already stand when the host returns
    repeat (10) begin
      if (reg_wr_o === 1'b1 && nwr < 8) begin
        wa[nwr] = reg_addr_o;
        wd[nwr] = reg_data_o;
        nwr++;
      end
      if (resp_req_o === 1'b1) begin
        nresp++;
        rf = resp_first_o;
      end
      if (trig_stb_o === 1'b1) ntrig++;
      @(negedge mclk_i);
    end
  endtask

  initial begin
    #200000;
    miscompares++;
    finish_test();
  end

  initial begin
    repeat (8) @(negedge mclk_i);
    rstn_i = 1'b1;
    check("scratch reset", scratch_byte_o, `SCRATCH_BYTE_RST);
    seed = xs(seed);
    g = seed[7:0];
    a = {2'h1, seed[13:8]};
    d = seed[23:16];
    group_id_i = g;
    tx({8'hB1, g, a, d, 32'h0}, 4, 1'b1);
    check("group wr count", nwr, 1);
    check("group wr addr", wa[0], {8'h00, a});
    check("group wr data", wd[0], d);
    check("group no resp", nresp, 0);
    tx({8'hB1, g ^ 8'h01, a, d, 32'h0}, 4, 1'b1);
    check("group miss", nwr + nresp, 0);
    tx({8'hB1, g, a, d, 32'h0}, 4, 1'b0);
    check("bad crc", nwr, 0);
    tx({8'h71, 8'hC8, d, 40'h0}, 3, 1'b1);
    check("response frame", nwr + nresp, 0);
    tx({8'hF1, 8'hC8, ~d, 40'h0}, 3, 1'b1);
    check("bcast wr count", nwr, 1);
    check("bcast wr addr", wa[0], `SCRATCH_BYTE_ADDR);
    check("scratch value", scratch_byte_o, 8'(~d));
    check("bcast no resp", nresp, 0);
    seed = xs(seed);
    tx({8'hFB, 8'h01, a, seed[23:0], 16'h0}, 6, 1'b1);
    check("wide wr count", nwr, 3);
    for (int i = 0; i < 3; i++) begin
      check("wide wr addr", wa[i], {8'h01, a} + 16'(i));
      check("wide wr data", wd[i], seed[23 - 8 * i -: 8]);
    end
    for (int k = 0; k < 4; k++) begin
      seed = xs(seed);
      h = seed[4:0];
      l = (k == 0) ? 7'h7F : seed[14:8];
      dev_addr_i = (k == 0) ? h : seed[20:16];
      tx({8'hE2, 8'h10, 3'h0, h, 1'b0, l, 32'h0}, 4, 1'b1);
      check("resp request", nresp, (dev_addr_i <= h) ? 1 : 0);
      check("resp no write", nwr, 0);
      check("resp high two", resp_high_o, h);
      check("resp len two", resp_len_o, l);
      if (nresp == 1) check("resp first", rf, dev_addr_i == h);
    end
    seed = xs(seed);
    b = seed[7:0];
    dev_addr_i = b[4:0];
    tx({8'hE1, 8'h10, b, 40'h0}, 3, 1'b1);
    check("resp req one", nresp, 1);
    check("resp len one", resp_len_o, {4'h0, b[7:5]});
    check("resp high one", resp_high_o, b[4:0]);
    check("resp first one", rf, 1'b1);
    for (int k = 0; k < 2; k++) begin
      seed = xs(seed);
      chan_sel_i = (k == 0) ? 32'h0000_0000 : seed;
      dev_addr_i = 5'h05;
      tx({8'hE2, 8'h02, seed[7:0], 8'h05, 32'h0}, 4, 1'b1);
      check("trig strobe", ntrig, 1);
      check("trig value", trig_val_o, seed[7:0]);
      check("trig resp", nresp, 1);
      check("trig len", resp_len_o, trig_len(chan_sel_i));
    end
    finish_test();
  end
endmodule // chain_write_frame_decoder_test

// >>> bench/host_frame_model.sv
`timescale 1ns/1ps
// Single host on the chain: sends whole command and response frames, one byte a cycle
module host_frame_model (
  input wire logic mclk_i,
  output logic rx_valid_o,
  output logic rx_sof_o,
  output logic [7:0] rx_byte_o,
  output logic frame_end_o,
  output logic crc_ok_o
);
  initial begin
    rx_valid_o = 1'b0;
    rx_sof_o = 1'b0;
    rx_byte_o = 8'h00;
    frame_end_o = 1'b0;
    crc_ok_o = 1'b0;
  end

  // Bytes are packed first byte on top; two CRC bytes follow, then the end pulse
  task automatic send(input logic [63:0] fb, input int n, input logic good);
    for (int i = 0; i < n + 2; i++) begin
      @(negedge mclk_i);
      rx_valid_o = 1'b1;
      rx_sof_o = (i == 0);
      // CRC value itself is judged outside this block, so any pattern will do
      rx_byte_o = (i < n) ? fb[63 - 8 * i -: 8] : 8'hA5 ^ 8'(i);
    end
    @(negedge mclk_i);
    rx_valid_o = 1'b0;
    rx_sof_o = 1'b0;
    // Released line shows no stale byte
    rx_byte_o = ~rx_byte_o;
    frame_end_o = 1'b1;
    crc_ok_o = good;
    @(negedge mclk_i);
    frame_end_o = 1'b0;
    crc_ok_o = ~good;
  endtask
endmodule // host_frame_model

// >>> rtl/chain_frame_defines.svh
`ifndef CHAIN_FRAME_DEFINES_SVH
`define CHAIN_FRAME_DEFINES_SVH

// Frame-initialization byte layout
`define INIT_KIND_BIT 7
`define INIT_REQ_HI 6
`define INIT_REQ_LO 4
`define INIT_AW_BIT 3
`define INIT_SIZE_HI 2
`define INIT_SIZE_LO 0

// Request kinds with the frame-kind bit set
`define REQ_GROUP_NORESP 3'h3
`define REQ_BCAST_RESP 3'h6
`define REQ_BCAST_NORESP 3'h7

// Register addresses and scratch byte reset value
`define ACTION_TRIGGER_ADDR 16'h0002
`define SCRATCH_BYTE_ADDR 16'h00C8
`define SCRATCH_BYTE_RST 8'h00

// One-byte response request: count-1 on top, highest responder below
`define RESP1_LEN_HI 7
`define RESP1_LEN_LO 5
`define RESP_HIGH_HI 4
`define RESP_HIGH_LO 0

// Frame tail and payload buffer
`define CRC_BYTES 2'h2
`define PAY_DEPTH 7

// Bytes per selected channel in a command-triggered response
`define BYTES_PER_CHAN 1

`endif

// >>> rtl/chain_frame_pkg.sv
package chain_frame_pkg;
  `include "chain_frame_defines.svh"

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SKIP,
    ST_GROUP,
    ST_ADDR_HI,
    ST_ADDR_LO,
    ST_DATA,
    ST_CRC,
    ST_EXEC
  } dec_state_e;

  typedef logic [`PAY_DEPTH-1:0][7:0] payload_t;

  typedef struct packed {
    dec_state_e st;
    logic [7:0] init;
    logic grp_hit;
    logic [15:0] addr;
    logic [2:0] cnt;
    logic [1:0] crc_n;
    payload_t pay;
    logic [2:0] idx;
    logic wr;
    logic [15:0] wr_addr;
    logic [7:0] wr_data;
    logic cmd_stb;
    logic [7:0] cmd_val;
    logic [7:0] scratch;
    logic resp_req;
    logic [6:0] resp_len;
    logic [4:0] resp_high;
    logic resp_first;
  } dec_state_s;
endpackage

// >>> rtl/chain_write_frame_decoder.sv
`timescale 1ns/1ps
`include "chain_frame_defines.svh"
// Behaviour
// - Frame kind 1, request 011 is group write without response; never respond.
// - Group write stores payload into addressed register when group identifier matches.
// - Address-width bit 0 means one 8-bit register address byte.
// - Init byte: bit7 frame kind, 6-4 request, 3 width, 2-0 payload count.
// - Frame kind 1 with request 110 is broadcast write with response.
// - Broadcast with response reads payload differently when targeting the action trigger.
// - Action-trigger broadcast response length comes from own channel-select contents.
// - Broadcast frames have no group byte; address follows init byte directly.
// - Two-byte request: highest responder address, then response count minus one.
// - One-byte request: top three bits count minus one, low five highest address.
// - Device at highest-responder address transmits its response first.
// - Frame kind 1, request 111 is broadcast write without response; never respond.
// - Broadcast write without response is executed by every device on the chain.
// - Frame kind bit cleared marks a response frame; not decoded as command.
// - Responses go in descending address order, each a complete frame.
// - Response payload length runs from one to 128 bytes.
// - Wide addressing adds a most significant address byte before the low byte.
module chain_write_frame_decoder
  import chain_frame_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic rx_valid_i,
  input wire logic rx_sof_i,
  input wire logic [7:0] rx_byte_i,
  input wire logic frame_end_i,
  input wire logic crc_ok_i,
  input wire logic [4:0] dev_addr_i,
  input wire logic [7:0] group_id_i,
  input wire logic [31:0] chan_sel_i,
  output logic reg_wr_o,
  output logic [15:0] reg_addr_o,
  output logic [7:0] reg_data_o,
  output logic trig_stb_o,
  output logic [7:0] trig_val_o,
  output logic [7:0] scratch_byte_o,
  output logic resp_req_o,
  output logic [6:0] resp_len_o,
  output logic [4:0] resp_high_o,
  output logic resp_first_o
);
  dec_state_s q, d;

  resp_size_if size_if ();

  resp_sizer u_sizer (
    .sz(size_if.sizer)
  );

  assign size_if.chan_sel = chan_sel_i;

  logic [2:0] rx_kind;
  logic [2:0] req_kind;
  logic [2:0] pay_size;
  logic wide_addr;
  logic tail_ok;
  logic [15:0] issue_addr;
  logic [7:0] issue_data;

  assign rx_kind = rx_byte_i[`INIT_REQ_HI:`INIT_REQ_LO];
  assign req_kind = q.init[`INIT_REQ_HI:`INIT_REQ_LO];
  assign pay_size = q.init[`INIT_SIZE_HI:`INIT_SIZE_LO];
  assign wide_addr = q.init[`INIT_AW_BIT];
  assign tail_ok = frame_end_i && crc_ok_i && (q.crc_n == `CRC_BYTES);
  assign issue_addr = q.addr + {13'h0, q.idx};
  assign issue_data = q.pay[q.idx];

  always_comb begin
    logic [4:0] high;
    logic [6:0] len;
    high = 5'h00;
    len = 7'h00;
    d = q;
    d.wr = 1'b0;
    d.cmd_stb = 1'b0;
    d.resp_req = 1'b0;
    if (rx_valid_i && rx_sof_i) begin
      // A new frame start always wins, so a truncated frame never executes
      d.init = rx_byte_i;
      d.cnt = 3'h0;
      d.crc_n = 2'h0;
      d.idx = 3'h0;
      d.grp_hit = 1'b0;
      d.addr = 16'h0000;
      if (!rx_byte_i[`INIT_KIND_BIT]) begin
        d.st = ST_SKIP;
      end else if (rx_kind == `REQ_GROUP_NORESP) begin
        d.st = ST_GROUP;
      end else if (rx_kind == `REQ_BCAST_RESP || rx_kind == `REQ_BCAST_NORESP) begin
        d.st = rx_byte_i[`INIT_AW_BIT] ? ST_ADDR_HI : ST_ADDR_LO;
      end else begin
        d.st = ST_SKIP;
      end
    end else begin
      case (q.st)
        ST_GROUP: begin
          if (rx_valid_i) begin
            d.grp_hit = (rx_byte_i == group_id_i);
            d.st = wide_addr ? ST_ADDR_HI : ST_ADDR_LO;
          end
        end
        ST_ADDR_HI: begin
          if (rx_valid_i) begin
            d.addr[15:8] = rx_byte_i;
            d.st = ST_ADDR_LO;
          end
        end
        ST_ADDR_LO: begin
          if (rx_valid_i) begin
            d.addr[7:0] = rx_byte_i;
            d.st = (pay_size == 3'h0) ? ST_CRC : ST_DATA;
          end
        end
        ST_DATA: begin
          if (rx_valid_i) begin
            d.pay[q.cnt] = rx_byte_i;
            d.cnt = q.cnt + 3'h1;
            if (q.cnt + 3'h1 == pay_size) begin
              d.st = ST_CRC;
            end
          end
        end
        ST_CRC: begin
          if (rx_valid_i && q.crc_n != `CRC_BYTES) begin
            d.crc_n = q.crc_n + 2'h1;
          end
          if (frame_end_i) begin
            d.st = ST_IDLE;
            if (tail_ok) begin
              if (req_kind == `REQ_GROUP_NORESP) begin
                if (q.grp_hit && pay_size != 3'h0) begin
                  d.st = ST_EXEC;
                end
              end else if (req_kind == `REQ_BCAST_NORESP) begin
                if (pay_size != 3'h0) begin
                  d.st = ST_EXEC;
                end
              end else begin
                if (q.addr == `ACTION_TRIGGER_ADDR) begin
                  // Trigger byte first, optional highest responder next
                  high = (pay_size >= 3'h2) ? q.pay[1][`RESP_HIGH_HI:`RESP_HIGH_LO] : dev_addr_i;
                  len = size_if.len_m1;
                  if (pay_size != 3'h0) begin
                    d.wr = 1'b1;
                    d.wr_addr = q.addr;
                    d.wr_data = q.pay[0];
                    d.cmd_stb = 1'b1;
                    d.cmd_val = q.pay[0];
                  end
                end else if (pay_size == 3'h1) begin
                  high = q.pay[0][`RESP_HIGH_HI:`RESP_HIGH_LO];
                  len = {4'h0, q.pay[0][`RESP1_LEN_HI:`RESP1_LEN_LO]};
                end else begin
                  high = q.pay[0][`RESP_HIGH_HI:`RESP_HIGH_LO];
                  len = q.pay[1][6:0];
                end
                d.resp_high = high;
                d.resp_len = len;
                // Only devices at or below the highest address answer
                d.resp_req = (dev_addr_i <= high);
                d.resp_first = (dev_addr_i == high);
              end
            end
          end
        end
        ST_EXEC: begin
          // Multi-byte payloads land at consecutive addresses, one per cycle
          d.wr = 1'b1;
          d.wr_addr = issue_addr;
          d.wr_data = issue_data;
          if (issue_addr == `SCRATCH_BYTE_ADDR) begin
            d.scratch = issue_data;
          end
          if (issue_addr == `ACTION_TRIGGER_ADDR) begin
            d.cmd_stb = 1'b1;
            d.cmd_val = issue_data;
          end
          d.idx = q.idx + 3'h1;
          if (q.idx + 3'h1 == pay_size) begin
            d.st = ST_IDLE;
          end
        end
        default: begin
          if (frame_end_i) begin
            d.st = ST_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      q <= '0;
      q.st <= ST_IDLE;
      q.scratch <= `SCRATCH_BYTE_RST;
    end else begin
      q <= d;
    end
  end

  assign reg_wr_o = q.wr;
  assign reg_addr_o = q.wr_addr;
  assign reg_data_o = q.wr_data;
  assign trig_stb_o = q.cmd_stb;
  assign trig_val_o = q.cmd_val;
  assign scratch_byte_o = q.scratch;
  assign resp_req_o = q.resp_req;
  assign resp_len_o = q.resp_len;
  assign resp_high_o = q.resp_high;
  assign resp_first_o = q.resp_first;

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rstn_i);

  sequence s_tail_seen;
    q.st == ST_CRC && tail_ok;
  endsequence

  sequence s_group_nr_miss;
    s_tail_seen ##0 (req_kind == `REQ_GROUP_NORESP) && !q.grp_hit;
  endsequence

  sequence s_bcast_nr_go;
    s_tail_seen ##0 (req_kind == `REQ_BCAST_NORESP) && pay_size != 3'h0;
  endsequence

  chk_no_resp_kinds: assert property (resp_req_o |-> $past(req_kind) == `REQ_BCAST_RESP)
    else $error("response requested for a write without response");

  chk_group_miss: assert property (s_group_nr_miss |=> !reg_wr_o [*4])
    else $error("group mismatch still wrote a register");

  // The issue state needs one cycle to form the first write, so it shows two edges after the tail
  chk_group_write: assert property (s_tail_seen ##0 req_kind == `REQ_GROUP_NORESP && q.grp_hit
      && pay_size != 3'h0 |=> ##1 reg_wr_o && reg_addr_o == $past(q.addr, 2)
      && reg_data_o == $past(q.pay[0], 2))
    else $error("group write did not store first payload byte");

  chk_bcast_write: assert property (s_bcast_nr_go |=> ##1 reg_wr_o && reg_addr_o == $past(q.addr, 2))
    else $error("broadcast write not executed");

  chk_scratch_store: assert property (reg_wr_o && reg_addr_o == `SCRATCH_BYTE_ADDR
      |-> scratch_byte_o == reg_data_o)
    else $error("scratch byte not updated by its write");

  chk_init_decode: assert property (rx_valid_i && rx_sof_i && !rx_byte_i[`INIT_KIND_BIT]
      |=> q.st == ST_SKIP)
    else $error("response frame decoded as command");

  chk_bcast_no_group: assert property (rx_valid_i && rx_sof_i && rx_byte_i[`INIT_KIND_BIT]
      && rx_kind == `REQ_BCAST_RESP && !rx_byte_i[`INIT_AW_BIT] |=> q.st == ST_ADDR_LO)
    else $error("broadcast frame did not go straight to address byte");

  chk_wide_addr: assert property (q.st == ST_ADDR_HI && rx_valid_i && !rx_sof_i
      |=> q.st == ST_ADDR_LO && q.addr[15:8] == $past(rx_byte_i))
    else $error("high register address byte not captured");

  chk_resp_first: assert property (resp_req_o |-> resp_first_o == (dev_addr_i == resp_high_o)
      && dev_addr_i <= resp_high_o)
    else $error("responder order flag wrong");

  chk_trigger_len: assert property (s_tail_seen ##0 req_kind == `REQ_BCAST_RESP
      && q.addr == `ACTION_TRIGGER_ADDR |=> resp_len_o == $past(size_if.len_m1))
    else $error("trigger response length not from channel select");

  chk_trig_with_wr: assert property (trig_stb_o |-> reg_wr_o && reg_addr_o == `ACTION_TRIGGER_ADDR
      && reg_data_o == trig_val_o)
    else $error("trigger strobe without matching register write");

  chk_one_byte_req: assert property (s_tail_seen ##0 req_kind == `REQ_BCAST_RESP && pay_size == 3'h1
      && q.addr != `ACTION_TRIGGER_ADDR |=> resp_len_o == {4'h0, $past(q.pay[0][7:5])}
      && resp_high_o == $past(q.pay[0][4:0]))
    else $error("one-byte response request decoded wrongly");

  chk_two_byte_req: assert property (s_tail_seen ##0 req_kind == `REQ_BCAST_RESP && pay_size == 3'h2
      && q.addr != `ACTION_TRIGGER_ADDR |=> resp_high_o == $past(q.pay[0][4:0])
      && resp_len_o == $past(q.pay[1][6:0]))
    else $error("two-byte response request decoded wrongly");
endmodule // chain_write_frame_decoder

// >>> rtl/resp_size_if.sv
`timescale 1ns/1ps
interface resp_size_if;
  logic [31:0] chan_sel;
  logic [6:0] len_m1;
  logic any_sel;
  modport sizer(input chan_sel, output len_m1, output any_sel);
  modport user(output chan_sel, input len_m1, input any_sel);
endinterface // resp_size_if

// >>> rtl/resp_sizer.sv
`timescale 1ns/1ps
`include "chain_frame_defines.svh"
module resp_sizer
  import chain_frame_pkg::*;
(
  resp_size_if.sizer sz
);
  // Running count of selected channels, one adder per bit
  logic [5:0] acc [0:32];

  assign acc[0] = 6'h00;

  genvar gi;
  generate
    for (gi = 0; gi < 32; gi++) begin : g_count
      assign acc[gi+1] = acc[gi] + {5'h00, sz.chan_sel[gi]};
    end
  endgenerate

  logic [7:0] bytes;

  // At most 32 channels of 1 byte keeps the length well under 128
  assign bytes = {2'h0, acc[32]} * 8'(`BYTES_PER_CHAN);
  assign sz.any_sel = (acc[32] != 6'h00);
  assign sz.len_m1 = sz.any_sel ? 7'(bytes - 8'h01) : 7'h00;
endmodule // resp_sizer
